/* File: dv/arith_bit_branch_exec_tb.sv */
// self-checking bench for the arithmetic, bit and branch execution block
`timescale 1ns/100ps
`default_nettype none
module arith_bit_branch_exec_tb;
  import exec_pkg::*;
  typedef struct {
    logic [42:0] v;
    string       what;
  } note_t;
  logic              clk_sys, rst, op_valid, target_sel, note_due;
  op_t               op_code;
  logic [ADDR_W-1:0] reg_index, reg_wr_addr;
  logic [BIT_W-1:0]  bit_num;
  logic [OFS_W-1:0]  jump_offset;
  logic [DATA_W-1:0] reg_rdata, acc, reg_wr_data, acc_m;
  logic              carry_flag, nibble_overflow_flag, zero_flag, reg_wr_en, idle_operation;
  logic              c_m, dc_m, z_m;
  logic [PC_W-1:0]   program_counter, pc_m;
  note_t             notes[$];
  int                mismatches, checks_done;

  arith_bit_branch_exec u_dut (
    .clk_sys(clk_sys), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .reg_index(reg_index), .target_sel(target_sel), .bit_num(bit_num),
    .jump_offset(jump_offset), .reg_rdata(reg_rdata), .acc(acc), .carry_flag(carry_flag),
    .nibble_overflow_flag(nibble_overflow_flag), .zero_flag(zero_flag),
    .program_counter(program_counter), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .idle_operation(idle_operation)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // comparison and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [42:0] seen, input logic [42:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  // write address and data only matter while the strobe is up
  function automatic logic [42:0] pack(input logic [7:0] a, input logic c, input logic dc,
                                       input logic z, input logic [14:0] pc, input logic we,
                                       input logic [6:0] wa, input logic [7:0] wd,
                                       input logic idl);
    return {a, c, dc, z, pc, we, we ? wa : 7'h00, we ? wd : 8'h00, idl};
  endfunction : pack

  function automatic logic [42:0] outs();
    return pack(acc, carry_flag, nibble_overflow_flag, zero_flag, program_counter, reg_wr_en,
                reg_wr_addr, reg_wr_data, idle_operation);
  endfunction : outs

  // ----------------------------------------------------------------
  // driver with reference model
  // ----------------------------------------------------------------
  task automatic run_op(input op_t op, input logic [6:0] idx, input logic t,
                        input logic [2:0] b, input logic [8:0] ofs, input logic [7:0] rd);
    logic [8:0] s;
    logic [7:0] res;
    logic       we, idl, cin;
    op_valid    <= 1'b1;
    op_code     <= op;
    reg_index   <= idx;
    target_sel  <= t;
    bit_num     <= b;
    jump_offset <= ofs;
    reg_rdata   <= rd;
    note_due    <= 1'b1;
    we   = 1'b0;
    idl  = 1'b0;
    res  = 8'h00;
    cin  = 1'b0;
    pc_m = pc_m + PC_STEP;
    case (op)
      OP_ADD_ACC_TO_REG, OP_ADD_WITH_CARRY_IN: begin
        if (op == OP_ADD_WITH_CARRY_IN) cin = c_m;
        s    = {1'b0, acc_m} + {1'b0, rd} + {8'h00, cin};
        dc_m = ({1'b0, acc_m[3:0]} + {1'b0, rd[3:0]} + {4'h0, cin}) > 5'h0F;
        res  = s[7:0];
        c_m  = s[8];
        z_m  = (res == 8'h00);
        we   = t;
        if (!t) acc_m = res;
      end
      // sign kept, carry from bit 0
      OP_ARITH_SHIFT_RIGHT: begin
        res = {rd[7], rd[7:1]};
        c_m = rd[0];
        z_m = (res == 8'h00);
        we  = t;
        if (!t) acc_m = res;
      end
      // one bit low, always to register
      OP_SINGLE_BIT_CLEAR: begin
        res = rd & ~(8'h01 << b);
        we  = 1'b1;
      end
      // low bit skips with idle cycle
      OP_SKIP_IF_BIT_LOW: if (!rd[b]) begin
        pc_m = pc_m + PC_STEP;
        idl  = 1'b1;
      end
      // counter plus one plus signed offset
      default: begin
        pc_m = pc_m + {{6{ofs[8]}}, ofs};
        idl  = 1'b1;
      end
    endcase
    notes.push_back('{pack(acc_m, c_m, dz(dc_m), z_m, pc_m, we, idx, res, idl), op.name()});
    @(posedge clk_sys);
    // the offered op in the idle cycle must leave no trace
    if (idl) begin
      op_code    <= op_t'($urandom_range(0, 5));
      target_sel <= 1'b1;
      reg_rdata  <= 8'($urandom);
      notes.push_back('{pack(acc_m, c_m, dc_m, z_m, pc_m, 1'b0, 7'h00, 8'h00, 1'b0), "discard"});
      @(posedge clk_sys);
    end
  endtask : run_op

  function automatic logic dz(input logic v);
    return v;
  endfunction : dz

  task automatic rnd_op();
    run_op(op_t'($urandom_range(0, 5)), 7'($urandom), 1'($urandom), 3'($urandom),
           9'($urandom), 8'($urandom));
  endtask : rnd_op

  task automatic do_reset(input int n);
    rst      <= 1'b1;
    op_valid <= 1'b0;
    note_due <= 1'b0;
    acc_m = ACC_RESET;
    c_m   = 1'b0;
    dc_m  = 1'b0;
    z_m   = 1'b0;
    pc_m  = PC_RESET;
    // the edge that drops rst still sees it high, so n edges in all
    repeat (n - 1) @(posedge clk_sys);
    @(negedge clk_sys);
    check(outs(), 43'h0, "reset");
    @(posedge clk_sys);
    rst <= 1'b0;
  endtask : do_reset

  // ----------------------------------------------------------------
  // monitor: one note per taken or discarded op
  // ----------------------------------------------------------------
  initial begin
    note_t n;
    forever begin
      @(posedge clk_sys);
      if (note_due) begin
        @(negedge clk_sys);
        n = notes.pop_front();
        check(outs(), n.v, n.what);
      end
    end
  end

  // the whole run is near 600 cycles; hang cut long after that
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    rst         = 1'b1;
    op_valid    = 1'b0;
    op_code     = OP_ADD_ACC_TO_REG;
    reg_index   = 7'h00;
    target_sel  = 1'b0;
    bit_num     = 3'h0;
    jump_offset = 9'h000;
    reg_rdata   = 8'h00;
    note_due    = 1'b0;
    mismatches  = 0;
    checks_done = 0;
    void'($urandom(32'h52DF));
    do_reset(6);
    $display("test reset done");
    run_op(OP_ADD_ACC_TO_REG, 7'h7F, 1'b0, 3'h0, 9'h000, 8'h9C);
    run_op(OP_ADD_WITH_CARRY_IN, 7'h7F, 1'b0, 3'h0, 9'h000, 8'h64);
    run_op(OP_ADD_WITH_CARRY_IN, 7'h01, 1'b1, 3'h0, 9'h000, 8'hFF);
    run_op(OP_ARITH_SHIFT_RIGHT, 7'h02, 1'b1, 3'h0, 9'h000, 8'h81);
    run_op(OP_ARITH_SHIFT_RIGHT, 7'h03, 1'b0, 3'h0, 9'h000, 8'h01);
    $display("test add and shift done");
    for (int b = 0; b < 8; b++) begin
      run_op(OP_SINGLE_BIT_CLEAR, 7'(b), 1'b0, 3'(b), 9'h000, 8'hFF);
      run_op(OP_SKIP_IF_BIT_LOW, 7'(b), 1'b0, 3'(b), 9'h000, 8'h01 << b);
      run_op(OP_SKIP_IF_BIT_LOW, 7'(b), 1'b0, 3'(b), 9'h000, ~(8'h01 << b));
    end
    $display("test bit ops done");
    run_op(OP_RELATIVE_JUMP, 7'h00, 1'b0, 3'h0, 9'h100, 8'h00);
    run_op(OP_RELATIVE_JUMP, 7'h00, 1'b0, 3'h0, 9'h0FF, 8'h00);
    run_op(OP_RELATIVE_JUMP, 7'h00, 1'b0, 3'h0, 9'h000, 8'h00);
    $display("test jumps done");
    repeat (400) rnd_op();
    $display("test random done");
    do_reset(2);
    repeat (50) rnd_op();
    $display("test second reset done");
    op_valid <= 1'b0;
    note_due <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    end_of_test();
  end
endmodule : arith_bit_branch_exec_tb
`default_nettype wire

/* File: src/arith_bit_branch_exec.sv */
// execution unit for add, shift, bit clear, bit skip and relative jump
`timescale 1ns/100ps
`default_nettype none
module arith_bit_branch_exec (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          op_valid,
  input  wire exec_pkg::op_t                 op_code,
  input  wire logic [exec_pkg::ADDR_W-1:0]   reg_index,
  input  wire logic                          target_sel,
  input  wire logic [exec_pkg::BIT_W-1:0]    bit_num,
  input  wire logic [exec_pkg::OFS_W-1:0]    jump_offset,
  input  wire logic [exec_pkg::DATA_W-1:0]   reg_rdata,
  output logic      [exec_pkg::DATA_W-1:0]   acc,
  output logic                               carry_flag,
  output logic                               nibble_overflow_flag,
  output logic                               zero_flag,
  output logic      [exec_pkg::PC_W-1:0]     program_counter,
  output logic                               reg_wr_en,
  output logic      [exec_pkg::ADDR_W-1:0]   reg_wr_addr,
  output logic      [exec_pkg::DATA_W-1:0]   reg_wr_data,
  output logic                               idle_operation
);
  import exec_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t             phase;
    logic               idle_op;
    logic [DATA_W-1:0]  acc;
    logic               c;
    logic               dc;
    logic               z;
    logic [PC_W-1:0]    pc;
    logic               wr_en;
    logic [ADDR_W-1:0]  wr_addr;
    logic [DATA_W-1:0]  wr_data;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic              exec_go;
  logic              add_cin;
  logic [DATA_W-1:0] add_sum;
  logic              add_cout;
  logic              add_nib;
  logic [DATA_W-1:0] shift_res;
  logic [DATA_W-1:0] clr_res;
  logic [PC_W-1:0]   ofs_ext;

  // an op is only taken in the execute phase; in the idle phase the
  // already fetched instruction is thrown away
  // discard in idle
  assign exec_go = op_valid && (s_q.phase == PH_EXEC);

  // ----------------------------------------------------------------
  // adder, shared by both add forms
  // ----------------------------------------------------------------
  // carry joins sum only for the carry-in add form
  assign add_cin = (op_code == OP_ADD_WITH_CARRY_IN) ? s_q.c : 1'b0;

  nibble_adder u_adder (
    .a           (s_q.acc),
    .b           (reg_rdata),
    .cin         (add_cin),
    .sum         (add_sum),
    .cout        (add_cout),
    .nibble_cout (add_nib)
  );

  assign shift_res = {reg_rdata[SIGN_POS], reg_rdata[DATA_W-1:1]};
  assign clr_res   = reg_rdata & ~(8'h01 << bit_num);
  assign ofs_ext   = {{(PC_W-OFS_W){jump_offset[OFS_SIGN]}}, jump_offset};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.wr_en   = 1'b0;
    s_d.idle_op = 1'b0;
    s_d.phase   = PH_EXEC;
    if (rst) begin
      s_d.acc     = ACC_RESET;
      s_d.c       = 1'b0;
      s_d.dc      = 1'b0;
      s_d.z       = 1'b0;
      s_d.pc      = PC_RESET;
      s_d.wr_addr = '0;
      s_d.wr_data = ACC_RESET;
    end else if (exec_go) begin
      s_d.pc      = s_q.pc + PC_STEP;
      s_d.wr_addr = reg_index;
      case (op_code)
        OP_ADD_ACC_TO_REG, OP_ADD_WITH_CARRY_IN: begin
          if (target_sel) begin
            s_d.wr_en   = 1'b1;
            s_d.wr_data = add_sum;
          end else begin
            s_d.acc = add_sum;
          end
          s_d.c  = add_cout;
          s_d.dc = add_nib;
          s_d.z  = (add_sum == 8'h00);
        end
        OP_ARITH_SHIFT_RIGHT: begin
          if (target_sel) begin
            s_d.wr_en   = 1'b1;
            s_d.wr_data = shift_res;
          end else begin
            s_d.acc = shift_res;
          end
          s_d.c = reg_rdata[0];
          s_d.z = (shift_res == 8'h00);
        end
        OP_SINGLE_BIT_CLEAR: begin
          s_d.wr_en   = 1'b1;
          s_d.wr_data = clr_res;
        end
        OP_SKIP_IF_BIT_LOW: begin
          if (!reg_rdata[bit_num]) begin
            s_d.pc      = s_q.pc + PC_SKIP;
            s_d.phase   = PH_IDLE;
            s_d.idle_op = 1'b1;
          end
        end
        OP_RELATIVE_JUMP: begin
          s_d.pc      = s_q.pc + PC_STEP + ofs_ext;
          s_d.phase   = PH_IDLE;
          s_d.idle_op = 1'b1;
        end
        default: begin
          s_d.pc = s_q.pc + PC_STEP;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  assign acc                  = s_q.acc;
  assign carry_flag           = s_q.c;
  assign nibble_overflow_flag = s_q.dc;
  assign zero_flag            = s_q.z;
  assign program_counter      = s_q.pc;
  assign reg_wr_en            = s_q.wr_en;
  assign reg_wr_addr          = s_q.wr_addr;
  assign reg_wr_data          = s_q.wr_data;
  assign idle_operation       = s_q.idle_op;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  add_to_acc_a: assert property (
    exec_go && op_code == OP_ADD_ACC_TO_REG && !target_sel
    |=> acc == $past(s_q.acc) + $past(reg_rdata) && !reg_wr_en)
    else $error("add to accumulator result wrong");

  add_to_reg_a: assert property (
    exec_go && op_code == OP_ADD_WITH_CARRY_IN && target_sel
    |=> reg_wr_en && reg_wr_addr == $past(reg_index)
        && reg_wr_data == 8'($past(s_q.acc) + $past(reg_rdata) + {7'h00, $past(s_q.c)})
        && acc == $past(s_q.acc))
    else $error("carry add to register wrong");

  carry_in_flag_a: assert property (
    exec_go && op_code == OP_ADD_WITH_CARRY_IN
    |=> carry_flag == 1'(({1'b0, $past(s_q.acc)} + {1'b0, $past(reg_rdata)}
                          + {8'h00, $past(s_q.c)}) >> 8))
    else $error("carry out of carry add wrong");

  nibble_zero_a: assert property (
    exec_go && op_code == OP_ADD_ACC_TO_REG
    |=> nibble_overflow_flag == 1'(({1'b0, $past(s_q.acc[3:0])}
                                    + {1'b0, $past(reg_rdata[3:0])}) >> 4)
        && zero_flag == (8'($past(s_q.acc) + $past(reg_rdata)) == 8'h00))
    else $error("nibble or zero flag wrong");

  shift_result_a: assert property (
    exec_go && op_code == OP_ARITH_SHIFT_RIGHT && target_sel
    |=> reg_wr_en && reg_wr_data[7] == $past(reg_rdata[7])
        && reg_wr_data[6:0] == $past(reg_rdata[7:1]) && carry_flag == $past(reg_rdata[0]))
    else $error("shift result wrong");

  shift_flags_a: assert property (
    exec_go && op_code == OP_ARITH_SHIFT_RIGHT
    |=> $stable(nibble_overflow_flag) && !(!$past(target_sel) && reg_wr_en))
    else $error("shift touched nibble flag or wrong target");

  bit_clear_a: assert property (
    exec_go && op_code == OP_SINGLE_BIT_CLEAR
    |=> reg_wr_en && reg_wr_data[$past(bit_num)] == 1'b0
        && (reg_wr_data | (8'h01 << $past(bit_num))) == ($past(reg_rdata) | (8'h01 << $past(bit_num)))
        && $stable({carry_flag, nibble_overflow_flag, zero_flag}))
    else $error("bit clear wrong");

  skip_timing_a: assert property (
    exec_go && op_code == OP_SKIP_IF_BIT_LOW && !reg_rdata[bit_num]
    |=> idle_operation && program_counter == $past(s_q.pc) + PC_SKIP
        ##1 !idle_operation && !reg_wr_en && $stable(program_counter))
    else $error("skip did not run idle cycle");

  no_skip_a: assert property (
    exec_go && op_code == OP_SKIP_IF_BIT_LOW && reg_rdata[bit_num]
    |=> !idle_operation && program_counter == $past(s_q.pc) + PC_STEP)
    else $error("skip taken on high bit");

  jump_target_a: assert property (
    exec_go && op_code == OP_RELATIVE_JUMP
    |=> program_counter == 15'($past(s_q.pc) + PC_STEP + $past(ofs_ext))
        && $stable({carry_flag, nibble_overflow_flag, zero_flag}))
    else $error("jump target wrong");

  jump_two_cycle_a: assert property (
    exec_go && op_code == OP_RELATIVE_JUMP |=> idle_operation ##1 $stable(program_counter))
    else $error("jump not two cycles");

  idle_no_effect_a: assert property (
    idle_operation |=> !reg_wr_en && $stable(acc) && $stable(program_counter))
    else $error("idle cycle had an effect");

endmodule : arith_bit_branch_exec
`default_nettype wire

/* File: src/exec_pkg.sv */
// shared constants and types for the arithmetic, bit and branch execution block
package exec_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned BIT_W  = 3;
  localparam int unsigned OFS_W  = 9;
  localparam int unsigned PC_W   = 15;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned SIGN_POS   = 7;
  localparam int unsigned NIBBLE_POS = 4;
  localparam int unsigned OFS_SIGN   = 8;

  // ----------------------------------------------------------------
  // values after reset and step counts
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET  = 15'h0000;
  localparam logic [PC_W-1:0]   PC_STEP   = 15'h0001;
  localparam logic [PC_W-1:0]   PC_SKIP   = 15'h0002;
  localparam int unsigned       LONG_OP_CYCLES = 2;

  // ----------------------------------------------------------------
  // operations and phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_ADD_ACC_TO_REG,
    OP_ARITH_SHIFT_RIGHT,
    OP_ADD_WITH_CARRY_IN,
    OP_SINGLE_BIT_CLEAR,
    OP_SKIP_IF_BIT_LOW,
    OP_RELATIVE_JUMP
  } op_t;

  typedef enum logic {
    PH_EXEC,
    PH_IDLE
  } phase_t;

endpackage : exec_pkg

/* File: src/nibble_adder.sv */
// 8-bit adder with carry in, carry out and nibble carry out
`timescale 1ns/100ps
`default_nettype none
module nibble_adder (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  output logic      [7:0] sum,
  output logic            cout,
  output logic            nibble_cout
);
  logic [4:0] low;
  logic [4:0] high;

  // ----------------------------------------------------------------
  // two nibble stages so the bit 3 carry is visible
  // ----------------------------------------------------------------
  always_comb begin
    low         = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    high        = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low[4]};
    sum         = {high[3:0], low[3:0]};
    cout        = high[4];
    nibble_cout = low[4];
  end
endmodule : nibble_adder
`default_nettype wire
